// ---- hdl/fep_pkg.sv ----
// Package with constants and carrier types for the flash erase and protection controller.
package fep_pkg;

    // ****************************************************************
    // Array geometry
    // ****************************************************************
    localparam int FLASH_BYTES = 262144;
    localparam int BLOCK_BYTES = 1024;
    localparam int UNIT_BLOCKS = 2;
    localparam int WORD_BYTES = 4;
    localparam int NUM_BLOCKS = FLASH_BYTES / BLOCK_BYTES;
    localparam int NUM_UNITS = NUM_BLOCKS / UNIT_BLOCKS;
    localparam int WORDS_PER_BLOCK = BLOCK_BYTES / WORD_BYTES;
    localparam int ADDR_W = 18;
    localparam int WADDR_W = ADDR_W - 2;
    localparam int BLK_W = 8;
    localparam int UNIT_W = 7;
    localparam int OFS_W = 8;
    localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;

    // ****************************************************************
    // Protection modes
    // ****************************************************************
    typedef enum logic [1:0] {
        FEP_PROT_NONE = 2'h0,
        FEP_PROT_RO = 2'h1,
        FEP_PROT_XO = 2'h2
    } fep_prot_t;

    localparam logic [1:0] PROT_RESET = 2'h0;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic valid;
        logic fetch;
        logic debug;
        logic [ADDR_W-1:0] addr;
    } fep_rd_req_t;

    typedef struct packed {
        logic valid;
        logic erase;
        logic [ADDR_W-1:0] addr;
        logic [31:0] data;
    } fep_wr_req_t;

    typedef struct packed {
        logic refusedErase;
        logic refusedProgram;
        logic refusedRead;
    } fep_status_t;

endpackage : fep_pkg

// ---- hdl/fep_unit_guard.sv ----
// One protection unit: holds its mode and decides which accesses it permits.
`timescale 1ns/10ps
`default_nettype none

module fep_unit_guard (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic setEn,
    input wire logic [1:0] setMode,
    output logic [1:0] mode,
    output logic writeOk,
    output logic dataReadOk
);
    logic [1:0] mode_q;
    logic [1:0] mode_d;

    always_comb begin
        mode_d = mode_q;
        if (setEn) begin
            mode_d = setMode;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= fep_pkg::PROT_RESET;
        end else begin
            mode_q <= mode_d;
        end
    end

    assign mode = mode_q;
    // Read-only and execute-only both forbid erase and program.
    assign writeOk = (mode_q == fep_pkg::FEP_PROT_NONE);
    // Execute-only hides contents from every data read.
    assign dataReadOk = (mode_q != fep_pkg::FEP_PROT_XO);

endmodule : fep_unit_guard

`default_nettype wire

// ---- hdl/fep_ctrl.sv ----
// Flash array controller with per-block erase and per-unit protection gating.
// Notes on behaviour
// - 256 KB array, 1 KB blocks erased independently.
// - Erase sets every bit of block.
// - Protection per 2 KB unit of two blocks.
// - Each unit selectable read-only or execute-only.
// - Read-only units refuse erase and program.
// - Execute-only units refuse erase and program.
// - Execute-only: non-debug fetches only, data reads and debug fetches denied.
// - Reads complete in one cycle.
`timescale 1ns/10ps
`default_nettype none

module fep_ctrl #(
    parameter int ADDR_W = fep_pkg::ADDR_W
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire fep_pkg::fep_rd_req_t rdReq,
    output logic rdAck,
    output logic rdDenied,
    output logic [31:0] rdData,
    input wire fep_pkg::fep_wr_req_t wrReq,
    output logic wrBusy,
    output logic wrDone,
    output logic wrDenied,
    input wire logic protSet,
    input wire logic [fep_pkg::UNIT_W-1:0] protUnit,
    input wire logic [1:0] protMode,
    output logic [1:0] protModeRd,
    input wire logic statusClear,
    output fep_pkg::fep_status_t status
);
    // ****************************************************************
    // Parameter check
    // ****************************************************************
    if (ADDR_W != fep_pkg::ADDR_W) begin : g_bad_addr
        $error("Address width must match the 256 KB array");
    end

    typedef enum logic [1:0] {
        FEP_IDLE = 2'h1,
        FEP_ERASE = 2'h2
    } fep_state_t;

    // ****************************************************************
    // Storage and protection units
    // ****************************************************************
    logic [31:0] mem_q [fep_pkg::FLASH_BYTES/fep_pkg::WORD_BYTES];
    logic [fep_pkg::NUM_UNITS-1:0] unitWriteOk;
    logic [fep_pkg::NUM_UNITS-1:0] unitReadOk;
    logic [1:0] unitMode [fep_pkg::NUM_UNITS];

    for (genvar u = 0; u < fep_pkg::NUM_UNITS; u++) begin : g_unit
        fep_unit_guard u_guard (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .setEn(protSet && (int'(protUnit) == u)),
            .setMode(protMode),
            .mode(unitMode[u]),
            .writeOk(unitWriteOk[u]),
            .dataReadOk(unitReadOk[u])
        );
    end

    assign protModeRd = unitMode[protUnit];

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic [fep_pkg::WADDR_W-1:0] rdWord;
    logic [fep_pkg::WADDR_W-1:0] wrWord;
    logic [fep_pkg::UNIT_W-1:0] rdUnit;
    logic [fep_pkg::UNIT_W-1:0] wrUnit;
    logic [fep_pkg::BLK_W-1:0] wrBlock;

    assign rdWord = rdReq.addr[ADDR_W-1:2];
    assign wrWord = wrReq.addr[ADDR_W-1:2];
    assign rdUnit = rdReq.addr[ADDR_W-1:ADDR_W-fep_pkg::UNIT_W];
    assign wrUnit = wrReq.addr[ADDR_W-1:ADDR_W-fep_pkg::UNIT_W];
    assign wrBlock = wrReq.addr[ADDR_W-1:ADDR_W-fep_pkg::BLK_W];

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic rdAllowed;
    logic rdRefuse;
    logic [31:0] rdData_q;
    logic [31:0] rdData_d;
    logic rdAck_q;
    logic rdAck_d;
    logic rdDenied_q;
    logic rdDenied_d;

    assign rdAllowed = rdReq.fetch && !rdReq.debug || unitReadOk[rdUnit];
    assign rdRefuse = rdReq.valid && !rdAllowed;

    always_comb begin
        rdData_d = 32'h00000000;
        rdAck_d = rdReq.valid;
        rdDenied_d = rdRefuse;
        if (rdReq.valid && rdAllowed) begin
            rdData_d = mem_q[rdWord];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q <= 32'h00000000;
            rdAck_q <= 1'b0;
            rdDenied_q <= 1'b0;
        end else begin
            rdData_q <= rdData_d;
            rdAck_q <= rdAck_d;
            rdDenied_q <= rdDenied_d;
        end
    end

    assign rdAck = rdAck_q;
    assign rdData = rdData_q;
    assign rdDenied = rdDenied_q;

    // ****************************************************************
    // Erase and program sequencer
    // ****************************************************************
    fep_state_t state_q;
    fep_state_t state_d;
    logic [fep_pkg::BLK_W-1:0] eBlock_q;
    logic [fep_pkg::BLK_W-1:0] eBlock_d;
    logic [fep_pkg::OFS_W-1:0] eOfs_q;
    logic [fep_pkg::OFS_W-1:0] eOfs_d;
    logic wrDone_q;
    logic wrDone_d;
    logic wrDenied_q;
    logic wrDenied_d;
    logic wrAccept;
    logic wrRefuse;
    logic memWe;
    logic [fep_pkg::WADDR_W-1:0] memAddr;
    logic [31:0] memData;

    assign wrAccept = wrReq.valid && (state_q == FEP_IDLE);
    assign wrRefuse = wrAccept && !unitWriteOk[wrUnit];

    always_comb begin
        state_d = state_q;
        eBlock_d = eBlock_q;
        eOfs_d = eOfs_q;
        wrDone_d = 1'b0;
        wrDenied_d = 1'b0;
        memWe = 1'b0;
        memAddr = wrWord;
        memData = wrReq.data;
        unique case (state_q)
            FEP_IDLE: begin
                if (wrRefuse) begin
                    wrDenied_d = 1'b1;
                    wrDone_d = 1'b1;
                end else if (wrAccept && wrReq.erase) begin
                    eBlock_d = wrBlock;
                    eOfs_d = '0;
                    state_d = FEP_ERASE;
                end else if (wrAccept) begin
                    // Programming only clears bits, as flash cells allow.
                    memWe = 1'b1;
                    memData = mem_q[wrWord] & wrReq.data;
                    wrDone_d = 1'b1;
                end
            end
            FEP_ERASE: begin
                memWe = 1'b1;
                memAddr = {eBlock_q, eOfs_q};
                memData = fep_pkg::ERASED_WORD;
                eOfs_d = eOfs_q + 8'h01;
                if (eOfs_q == 8'(fep_pkg::WORDS_PER_BLOCK - 1)) begin
                    state_d = FEP_IDLE;
                    wrDone_d = 1'b1;
                end
            end
            default: begin
                state_d = FEP_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= FEP_IDLE;
            eBlock_q <= '0;
            eOfs_q <= '0;
            wrDone_q <= 1'b0;
            wrDenied_q <= 1'b0;
        end else begin
            state_q <= state_d;
            eBlock_q <= eBlock_d;
            eOfs_q <= eOfs_d;
            wrDone_q <= wrDone_d;
            wrDenied_q <= wrDenied_d;
        end
    end

    // The array has no reset, as real flash keeps its contents.
    always_ff @(posedge ref_clk) begin
        if (memWe) begin
            mem_q[memAddr] <= memData;
        end
    end

    assign wrBusy = (state_q != FEP_IDLE);
    assign wrDone = wrDone_q;
    assign wrDenied = wrDenied_q;

    // ****************************************************************
    // Refusal status flags
    // ****************************************************************
    fep_pkg::fep_status_t status_q;
    fep_pkg::fep_status_t status_d;

    always_comb begin
        status_d = status_q;
        if (statusClear) begin
            status_d = '0;
        end
        // A refusal in the clearing cycle still sets its flag.
        if (wrRefuse && wrReq.erase) begin
            status_d.refusedErase = 1'b1;
        end
        if (wrRefuse && !wrReq.erase) begin
            status_d.refusedProgram = 1'b1;
        end
        if (rdRefuse) begin
            status_d.refusedRead = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    assign status = status_q;

endmodule : fep_ctrl

`default_nettype wire

// ---- verif/fep_ctrl_properties.sv ----
// Concurrent checks on the ports of the flash erase and protection controller.
`timescale 1ns/10ps
`default_nettype none
module fep_ctrl_properties #(parameter int ADDR_W = fep_pkg::ADDR_W) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire fep_pkg::fep_rd_req_t rdReq,
    input wire logic rdAck,
    input wire logic rdDenied,
    input wire logic [31:0] rdData,
    input wire fep_pkg::fep_wr_req_t wrReq,
    input wire logic wrBusy,
    input wire logic wrDone,
    input wire logic wrDenied,
    input wire logic protSet,
    input wire logic [fep_pkg::UNIT_W-1:0] protUnit,
    input wire logic [1:0] protMode,
    input wire logic [1:0] protModeRd,
    input wire logic statusClear,
    input wire fep_pkg::fep_status_t status
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence sweep_s;
        wrBusy throughout (##255 1'b1);
    endsequence
    sequence finish_s;
        !wrBusy && wrDone;
    endsequence
    read_ack_a: assert property (rdReq.valid |=> rdAck)
        else $error("read not answered");
    ack_cause_a: assert property (rdAck |-> $past(rdReq.valid))
        else $error("stray read answer");
    deny_zero_a: assert property (rdDenied |-> rdAck && rdData == 32'h0)
        else $error("denied read leaks data");
    prog_done_a: assert property (wrReq.valid && !wrReq.erase && !wrBusy |=> wrDone)
        else $error("program not finished");
    erase_start_a: assert property (wrReq.valid && wrReq.erase && !wrBusy |=> wrBusy != wrDenied)
        else $error("erase neither run nor refused");
    erase_len_a: assert property ($rose(wrBusy) |-> sweep_s ##1 finish_s)
        else $error("erase sweep length wrong");
    mode_load_a: assert property (protSet ##1 $stable(protUnit) |-> protModeRd == $past(protMode))
        else $error("mode not loaded");
    flag_hold_a: assert property ($fell(status.refusedRead) |-> $past(statusClear))
        else $error("read flag dropped");
endmodule : fep_ctrl_properties
bind fep_ctrl fep_ctrl_properties #(.ADDR_W(ADDR_W)) i_props (.ref_clk(ref_clk), .rst_n(rst_n),
    .rdReq(rdReq), .rdAck(rdAck), .rdDenied(rdDenied), .rdData(rdData), .wrReq(wrReq),
    .wrBusy(wrBusy), .wrDone(wrDone), .wrDenied(wrDenied), .protSet(protSet),
    .protUnit(protUnit), .protMode(protMode), .protModeRd(protModeRd),
    .statusClear(statusClear), .status(status));
`default_nettype wire

// ---- verif/fep_host_model.sv ----
// Processor and debugger side model issuing flash reads, programs and erases.
`timescale 1ns/10ps
`default_nettype none
module fep_host_model (
    input wire logic ref_clk,
    output fep_pkg::fep_rd_req_t rdReq,
    output fep_pkg::fep_wr_req_t wrReq,
    input wire logic wrDone,
    input wire logic wrDenied
);
    initial begin
        rdReq = '0;
        wrReq = '0;
    end
    // Released lines show inverted values so stale data cannot pass.
    task automatic rd(input logic f, input logic d, input logic [17:0] a);
        @(negedge ref_clk);
        rdReq = '{1'b1, f, d, a};
        @(negedge ref_clk);
        rdReq = '{1'b0, ~f, ~d, ~a};
    endtask : rd
    task automatic wr(input logic e, input logic [17:0] a, input logic [31:0] v, output logic den);
        int n;
        @(negedge ref_clk);
        wrReq = '{1'b1, e, a, v};
        @(negedge ref_clk);
        wrReq = '{1'b0, ~e, ~a, ~v};
        n = 0;
        while (wrDone !== 1'b1 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        // An operation that never finishes reports an unknown refusal, which no check accepts.
        den = (wrDone === 1'b1) ? wrDenied : 1'bx;
    endtask : wr
endmodule : fep_host_model
`default_nettype wire

// ---- verif/fep_ctrl_bench.sv ----
// Self-checking bench for the flash erase and protection controller.
`timescale 1ns/10ps
`default_nettype none
module fep_ctrl_bench;
    logic ref_clk, rst_n, protSet, statusClear, rdAck, rdDenied, wrBusy, wrDone, wrDenied, den;
    logic [6:0] protUnit;
    logic [1:0] protMode, protModeRd;
    logic [31:0] rdData;
    fep_pkg::fep_rd_req_t rdReq;
    fep_pkg::fep_wr_req_t wrReq;
    fep_pkg::fep_status_t status;
    int miscompares = 0;
    int n_tests = 0;
    // Row: mode, fetch, debug, expected denial.
    logic [4:0] rows [11] = '{5'h04, 5'h00, 5'h02, 5'h0C, 5'h08, 5'h0A, 5'h18, 5'h14, 5'h11,
        5'h13, 5'h17};
    fep_ctrl i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .rdReq(rdReq), .rdAck(rdAck),
        .rdDenied(rdDenied), .rdData(rdData), .wrReq(wrReq), .wrBusy(wrBusy), .wrDone(wrDone),
        .wrDenied(wrDenied), .protSet(protSet), .protUnit(protUnit), .protMode(protMode),
        .protModeRd(protModeRd), .statusClear(statusClear), .status(status));
    fep_host_model i_host (.ref_clk(ref_clk), .rdReq(rdReq), .wrReq(wrReq), .wrDone(wrDone),
        .wrDenied(wrDenied));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdc(input logic f, input logic d, input logic [17:0] a, input logic [31:0] e);
        i_host.rd(f, d, a);
        chk({31'h0, rdAck}, 32'h1);
        chk(rdData, e);
    endtask : rdc
    task automatic wrc(input logic er, input logic [17:0] a, input logic [31:0] v, input logic e);
        i_host.wr(er, a, v, den);
        chk({31'h0, den}, {31'h0, e});
    endtask : wrc
    task automatic setp(input logic [1:0] m);
        @(negedge ref_clk);
        protSet = 1'b1;
        protMode = m;
        @(negedge ref_clk);
        protSet = 1'b0;
        chk({30'h0, protModeRd}, {30'h0, m});
    endtask : setp
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #100us;
        miscompares++;
        report_and_stop();
    end
    initial begin
        rst_n = 1'b0;
        protSet = 1'b0;
        protUnit = 7'h00;
        protMode = 2'h0;
        statusClear = 1'b0;
        repeat (3) @(posedge ref_clk);
        chk({24'h0, rdAck, wrBusy, wrDone, status, protModeRd}, 32'h0);
        @(negedge ref_clk);
        rst_n = 1'b1;
        wrc(1'b1, 18'h00000, 32'h0, 1'b0);
        rdc(1'b0, 1'b0, 18'h00000, 32'hFFFFFFFF);
        rdc(1'b0, 1'b0, 18'h003FC, 32'hFFFFFFFF);
        wrc(1'b0, 18'h00000, 32'hA5A5A5A5, 1'b0);
        wrc(1'b0, 18'h00000, 32'h0F0F0F0F, 1'b0);
        wrc(1'b1, 18'h00400, 32'h0, 1'b0);
        rdc(1'b0, 1'b0, 18'h00000, 32'h05050505);
        rdc(1'b1, 1'b0, 18'h00400, 32'hFFFFFFFF);
        foreach (rows[i]) begin
            setp(rows[i][4:3]);
            i_host.rd(rows[i][2], rows[i][1], 18'h00000);
            chk({31'h0, rdDenied}, {31'h0, rows[i][0]});
            chk(rdData, rows[i][0] ? 32'h0 : 32'h05050505);
            wrc(1'b0, 18'h00004, 32'hFFFFFFFF, rows[i][4:3] != 2'h0);
        end
        wrc(1'b1, 18'h00800, 32'h0, 1'b0);
        rdc(1'b0, 1'b1, 18'h00800, 32'hFFFFFFFF);
        wrc(1'b1, 18'h00400, 32'h0, 1'b1);
        setp(2'h1);
        wrc(1'b1, 18'h00000, 32'h0, 1'b1);
        rdc(1'b0, 1'b1, 18'h00000, 32'h05050505);
        chk({29'h0, status}, 32'h7);
        @(negedge ref_clk);
        statusClear = 1'b1;
        @(negedge ref_clk);
        statusClear = 1'b0;
        chk({29'h0, status}, 32'h0);
        // A reset in mid-run must drop unit 0 back to unprotected.
        @(negedge ref_clk);
        rst_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk({29'h0, status}, 32'h0);
        chk({30'h0, protModeRd}, 32'h0);
        rst_n = 1'b1;
        // Protecting unit one must leave its neighbour writable.
        protUnit = 7'h01;
        setp(2'h1);
        wrc(1'b0, 18'h00800, 32'h0, 1'b1);
        wrc(1'b0, 18'h00000, 32'hFFFFFFFF, 1'b0);
        report_and_stop();
    end
endmodule : fep_ctrl_bench
`default_nettype wire
